// ### slpd_cfg.svh
// Purpose: constants for the serial line powerdown controller
// Assumes: 125 MHz clock, 8 ns period
// Notes:   times kept in their own unit, cycle counts derived
`ifndef SLPD_CFG_SVH
`define SLPD_CFG_SVH
`define SLPD_CLK_MHZ        125
`define SLPD_IDLE_S         30
// 64-bit product: thirty seconds of cycles does not fit a 32-bit int
`define SLPD_IDLE_CYC       (longint'(`SLPD_IDLE_S) * 1000000 * `SLPD_CLK_MHZ)
`define SLPD_INVAL_US       60
`define SLPD_INVAL_CYC      (`SLPD_INVAL_US * `SLPD_CLK_MHZ)
`define SLPD_VALID_US       1
`define SLPD_VALID_CYC      (`SLPD_VALID_US * `SLPD_CLK_MHZ)
`define SLPD_WAKE_US        25
`define SLPD_WAKE_CYC       (`SLPD_WAKE_US * `SLPD_CLK_MHZ)
`endif

// ### slpd_pkg.sv
// Purpose: types for the serial line powerdown controller
// Assumes: nothing
// Notes:   power modes and output enable bundle
package slpd_pkg;
  typedef enum logic [1:0] {
    SLPD_ON,
    SLPD_AUTO_DOWN,
    SLPD_FORCED_DOWN
  } slpd_mode_e;
  typedef struct packed {
    logic pump_on;
    logic tx_en;
    logic rx_en;
    logic tx_ready;
  } slpd_en_s;
endpackage : slpd_pkg

// ### slpd_ctrl.sv
// Purpose: power mode control, inactivity timer and validity status
// Assumes: all line levels arrive asynchronously and are synchronised here
// Notes:   analog pump and line drivers sit outside; this drives their enables
`timescale 1ns/100ps
`include "slpd_cfg.svh"

// Summary of operation
// RULE1: force sleep low always powers down
// RULE2: powerdown stops pump, transmitters go high-Z
// RULE3: host straps both high for always on
// RULE4: manual powerdown also disables standard receivers
// RULE5: transmit ready within 25 us of wake
// RULE6: manual down until both high or edge
// RULE7: force awake fall gives 30 s on
// RULE8: 30 s without edges powers down
// RULE9: any edge wakes from inactivity powerdown
// RULE10: auto powerdown only with awake low, sleep high
// RULE11: timer stays expired until awake rises or edge
// RULE12: status low after 60 us all invalid
// RULE13: status high 1 us after any valid
// RULE14: status never changes power state itself
// RULE15: status wired to both forces follows it
// RULE16: hybrid wiring needs valid levels plus edge
// RULE17: joined force pins act as shutdown
// RULE18: standard receivers stay on in auto down
// RULE19: monitor receiver always active
// RULE20: edge means crossing of input threshold
// RULE21: timers restart when condition breaks
module slpd_ctrl
  import slpd_pkg::*;
#(
  parameter int  N_TX        = 5,
  parameter int  N_RX        = 3,
  parameter longint IDLE_CYC = `SLPD_IDLE_CYC
) (
  input  wire logic              I_CLK,
  input  wire logic              I_RESETN,
  input  wire logic              i_force_awake_in,
  input  wire logic              i_force_sleep_n,
  input  wire logic [N_TX-1:0]   i_tx_in,
  input  wire logic [N_RX-1:0]   i_rx_in,
  input  wire logic [N_RX-1:0]   i_rx_valid,
  input  wire logic              i_monitor_rx_in,
  output logic                   o_pump_on,
  output logic                   o_tx_oe_n,
  output logic                   o_rx_oe_n,
  output logic                   o_tx_ready,
  output logic                   o_monitor_rx_out,
  output logic                   o_invalid_n,
  output slpd_pkg::slpd_mode_e   o_mode
);
  import slpd_pkg::*;

  localparam int W_IN  = 2 + N_TX + N_RX + N_RX + 1;
  localparam int IDLE_W = $clog2(IDLE_CYC + 1);
  localparam int INV_W  = $clog2(`SLPD_INVAL_CYC + 1);
  localparam int WAKE_W = $clog2(`SLPD_WAKE_CYC + 1);

  // refused at elaboration: the timers need at least one line and two idle cycles
  if (N_TX < 1 || N_RX < 1 || IDLE_CYC < 2) begin : g_bad_param
    $error("slpd_ctrl: bad parameters");
  end

  // ==========================================================================
  // input synchronisers
  // ==========================================================================
  logic [W_IN-1:0] raw;
  logic [W_IN-1:0] meta_reg;
  logic [W_IN-1:0] sync_reg;
  logic [W_IN-1:0] prev_reg;

  assign raw = {i_force_awake_in, i_force_sleep_n, i_tx_in, i_rx_in, i_rx_valid,
                i_monitor_rx_in};

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= raw;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  logic            awake_s;
  logic            sleep_n_s;
  logic [N_TX-1:0] tx_s;
  logic [N_RX-1:0] rx_s;
  logic [N_RX-1:0] valid_s;
  logic            mon_s;
  logic            awake_p;
  logic [N_TX-1:0] tx_p;
  logic [N_RX-1:0] rx_p;

  assign {awake_s, sleep_n_s, tx_s, rx_s, valid_s, mon_s} = sync_reg;
  assign awake_p = prev_reg[W_IN-1];
  assign tx_p    = prev_reg[N_RX+N_RX+1 +: N_TX];
  assign rx_p    = prev_reg[N_RX+1 +: N_RX];

  // the line inputs are already thresholded by the input comparators, so a
  // change of the synchronised level is exactly a threshold crossing
  logic activity;
  logic awake_rise;
  logic awake_fall;
  logic [2:0] fill_reg;
  logic       has_prev;
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) fill_reg <= 3'h0;
    else           fill_reg <= {fill_reg[1:0], 1'h1};
  end
  // edges count only once both compared stages hold real pin samples;
  // otherwise a pin idling high would look like an edge right after reset
  assign has_prev   = fill_reg[2];
  assign activity   = has_prev && ((tx_s != tx_p) || (rx_s != rx_p)); // RULE20
  assign awake_rise = has_prev && awake_s && !awake_p;
  assign awake_fall = has_prev && !awake_s && awake_p;

  // ==========================================================================
  // inactivity timer with sticky expiry
  // ==========================================================================
  logic [IDLE_W-1:0] idle_cnt_reg;
  logic              expired_reg;
  logic              forced_down;

  assign forced_down = !sleep_n_s; // RULE1 RULE17

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      idle_cnt_reg <= '0;
      expired_reg  <= 1'b0;
    end else if (activity || awake_s || awake_fall) begin
      // restart: a transition, force awake high, or its falling edge
      idle_cnt_reg <= '0; // RULE21 RULE7 RULE9
      expired_reg  <= 1'b0; // RULE11
    end else if (forced_down) begin
      expired_reg <= 1'b1; // RULE11 RULE6
    end else if (!expired_reg) begin
      if (idle_cnt_reg == IDLE_W'(IDLE_CYC - 1)) begin
        expired_reg <= 1'b1; // RULE8
      end else begin
        idle_cnt_reg <= idle_cnt_reg + 1'b1;
      end
    end
  end

  // ==========================================================================
  // power mode
  // ==========================================================================
  slpd_mode_e mode_next;
  always_comb begin
    if (forced_down) begin
      mode_next = SLPD_FORCED_DOWN; // RULE1
    end else if (awake_s) begin
      mode_next = SLPD_ON; // RULE10 RULE3
    end else if (expired_reg && !activity) begin
      mode_next = SLPD_AUTO_DOWN; // RULE10 RULE6 RULE16
    end else begin
      mode_next = SLPD_ON;
    end
  end

  // wake settle counter: transmit ready once the pump has had time to charge
  logic [WAKE_W-1:0] wake_cnt_reg;
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      wake_cnt_reg <= '0;
    end else if (mode_next != SLPD_ON) begin
      wake_cnt_reg <= '0;
    end else if (wake_cnt_reg != WAKE_W'(`SLPD_WAKE_CYC)) begin
      wake_cnt_reg <= wake_cnt_reg + 1'b1; // RULE5
    end
  end

  slpd_en_s en;
  always_comb begin
    en.pump_on  = (mode_next == SLPD_ON); // RULE2
    en.tx_en    = en.pump_on;
    en.rx_en    = (mode_next != SLPD_FORCED_DOWN); // RULE4 RULE18
    en.tx_ready = en.pump_on && (wake_cnt_reg >= WAKE_W'(`SLPD_WAKE_CYC - 1)); // RULE5
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      o_pump_on  <= 1'b0;
      o_tx_oe_n  <= 1'b1;
      o_rx_oe_n  <= 1'b1;
      o_tx_ready <= 1'b0;
      o_mode     <= SLPD_FORCED_DOWN;
    end else begin
      o_pump_on  <= en.pump_on;
      o_tx_oe_n  <= !en.tx_en; // RULE2
      o_rx_oe_n  <= !en.rx_en; // RULE4
      o_tx_ready <= en.tx_ready;
      o_mode     <= mode_next;
    end
  end

  // monitor receiver ignores every control input
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) o_monitor_rx_out <= 1'b0;
    else           o_monitor_rx_out <= mon_s; // RULE19
  end

  // ==========================================================================
  // validity detector, independent of the power mode
  // ==========================================================================
  logic [INV_W-1:0] inv_cnt_reg;
  logic [INV_W-1:0] val_cnt_reg;
  logic             any_valid;
  assign any_valid = |valid_s;

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      inv_cnt_reg <= '0;
      val_cnt_reg <= '0;
      o_invalid_n <= 1'b1;
    end else if (any_valid) begin
      inv_cnt_reg <= '0; // RULE21
      if (!o_invalid_n) begin
        if (val_cnt_reg == INV_W'(`SLPD_VALID_CYC - 1)) begin
          o_invalid_n <= 1'b1; // RULE13 RULE14
          val_cnt_reg <= '0;
        end else begin
          val_cnt_reg <= val_cnt_reg + 1'b1;
        end
      end
    end else begin
      val_cnt_reg <= '0; // RULE21
      if (o_invalid_n) begin
        if (inv_cnt_reg == INV_W'(`SLPD_INVAL_CYC - 1)) begin
          o_invalid_n <= 1'b0; // RULE12 RULE15
          inv_cnt_reg <= '0;
        end else begin
          inv_cnt_reg <= inv_cnt_reg + 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  sleep_wins_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RULE1
    !sleep_n_s |=> (o_mode == SLPD_FORCED_DOWN))
    else $error("force sleep did not power down");

  down_hiz_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RULE2
    (o_mode != SLPD_ON) |-> (o_tx_oe_n && !o_pump_on))
    else $error("transmitters driven in powerdown");

  rx_off_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RULE4
    (o_mode == SLPD_FORCED_DOWN) |-> o_rx_oe_n)
    else $error("receivers on in manual powerdown");

  rx_auto_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RULE18
    (o_mode == SLPD_AUTO_DOWN) |-> !o_rx_oe_n)
    else $error("receivers off in auto powerdown");

  // counts powered cycles still waiting for transmit ready; saturates so the
  // check keeps firing instead of wrapping back to a legal value
  logic [WAKE_W-1:0] ready_wait_reg;
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN || !o_pump_on || o_tx_ready) begin
      ready_wait_reg <= '0;
    end else if (ready_wait_reg != WAKE_W'(`SLPD_WAKE_CYC)) begin
      ready_wait_reg <= ready_wait_reg + 1'h1;
    end
  end

  wake_time_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RULE5
    ready_wait_reg < WAKE_W'(`SLPD_WAKE_CYC))
    else $error("transmit not ready in time");

  awake_on_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RULE10
    (awake_s && sleep_n_s) |=> (o_mode == SLPD_ON))
    else $error("awake input did not hold power on");

  edge_wake_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RULE9
    (activity && sleep_n_s) |=> o_pump_on)
    else $error("activity did not wake");

  sticky_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RULE11
    (expired_reg && !activity && !awake_s && !awake_fall) |=> expired_reg)
    else $error("expired timer cleared without cause");

  inval_rise_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RULE13
    (!o_invalid_n && any_valid) [*8] |-> ##[0:120] o_invalid_n)
    else $error("status did not return high");

  awake_clear_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RULE11
    awake_rise |=> !expired_reg)
    else $error("awake rise left timer expired");

  mon_rx_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RULE19
    o_monitor_rx_out == $past(mon_s))
    else $error("monitor receiver did not follow input");
endmodule : slpd_ctrl

// ### slpd_host.sv
// Purpose: host logic that drives the two force pins
// Assumes: plain levels, no clock of its own
// Notes:   sel 0 direct drive, 1 status to both pins, 2 status to sleep only
`timescale 1ns/100ps
module slpd_host (
  input  wire logic [1:0] i_sel,
  input  wire logic       i_awake,
  input  wire logic       i_sleep_n,
  input  wire logic       i_invalid_n,
  output logic            o_force_awake_in,
  output logic            o_force_sleep_n
);
  // ==========================================================
  // pin wiring
  always_comb begin
    o_force_awake_in = i_awake;
    o_force_sleep_n  = i_sleep_n;
    if (i_sel == 2'h1) begin
      o_force_awake_in = i_invalid_n;
      o_force_sleep_n  = i_invalid_n;
    end else if (i_sel == 2'h2) begin
      o_force_awake_in = 1'h0;
      o_force_sleep_n  = i_invalid_n;
    end
  end
endmodule : slpd_host

// ### testbench.sv
// Purpose: self-checking bench for the powerdown controller
// Assumes: idle count shortened to 200 cycles
// Notes:   expected states queued by the driver, compared by a monitor
`timescale 1ns/100ps
module testbench;
  import slpd_pkg::*;
  // ==========================================================
  // signals
  logic       clk, rstn, awake, sleep_n, mon_in, f_aw, f_sl;
  logic       o_pump_on, o_tx_oe_n, o_rx_oe_n, o_tx_ready, o_mon, o_invalid_n;
  logic [1:0] sel;
  logic [4:0] tx;
  logic [2:0] rx, rx_valid;
  slpd_mode_e o_mode;
  logic [4:0] q[$];
  event       smp;
  int         n_mismatch, cmp_count, i;

  slpd_ctrl #(.IDLE_CYC(200)) slpd_ctrl_inst (.I_CLK(clk), .I_RESETN(rstn),
    .i_force_awake_in(f_aw), .i_force_sleep_n(f_sl), .i_tx_in(tx), .i_rx_in(rx),
    .i_rx_valid(rx_valid), .i_monitor_rx_in(mon_in), .o_pump_on(o_pump_on),
    .o_tx_oe_n(o_tx_oe_n), .o_rx_oe_n(o_rx_oe_n), .o_tx_ready(o_tx_ready),
    .o_monitor_rx_out(o_mon), .o_invalid_n(o_invalid_n), .o_mode(o_mode));
  slpd_host slpd_host_inst (.i_sel(sel), .i_awake(awake), .i_sleep_n(sleep_n),
    .i_invalid_n(o_invalid_n), .o_force_awake_in(f_aw), .o_force_sleep_n(f_sl));

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // ==========================================================
  // compare and helper tasks
  task automatic cmp(input logic [4:0] e, input logic [4:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp
  task automatic cmp_bit(input logic e, input logic g);
    cmp({4'h0, e}, {4'h0, g});
  endtask : cmp_bit
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // enables follow the mode; 5 cycles covers sync plus output register
  task automatic exp_st(input slpd_mode_e m);
    q.push_back({m, m == SLPD_ON, m != SLPD_ON, m == SLPD_FORCED_DOWN});
    cyc(5);
    #1 -> smp;
  endtask : exp_st
  always @(smp) cmp(q.pop_front(), {o_mode, o_pump_on, o_tx_oe_n, o_rx_oe_n});
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  // watchdog sized well above the roughly 26k cycles of the sequence
  initial begin
    cyc(60000);
    n_mismatch++;
    summarize();
  end

  // ==========================================================
  // main sequence
  initial begin
    {rstn, sleep_n, awake, mon_in} = 4'h7;
    {sel, tx, rx} = 10'h000;
    rx_valid = 3'h7;
    i = $urandom(46703);
    cyc(8);
    rstn <= 1'h1;
    for (i = 0; i < 20 && o_mode !== SLPD_ON; i++) begin
      cyc(1);
      #1;
    end
    cyc(3120);
    #1 cmp_bit(1'h0, o_tx_ready);
    cyc(10);
    #1 cmp_bit(1'h1, o_tx_ready);
    exp_st(SLPD_ON);
    @(posedge clk) awake <= 1'h0;
    cyc(145);
    exp_st(SLPD_ON);
    cyc(60);
    exp_st(SLPD_AUTO_DOWN);
    @(posedge clk) rx <= rx ^ 3'(1 << ($urandom % 3));
    exp_st(SLPD_ON);
    @(posedge clk) {sleep_n, awake, mon_in} <= {2'h1, 1'($urandom)};
    exp_st(SLPD_FORCED_DOWN);
    cmp_bit(mon_in, o_mon);
    // awake falls while still forced, so the timer is left expired
    @(posedge clk) awake <= 1'h0;
    exp_st(SLPD_FORCED_DOWN);
    @(posedge clk) sleep_n <= 1'h1;
    exp_st(SLPD_AUTO_DOWN);
    @(posedge clk) tx <= tx ^ 5'(1 << ($urandom % 5));
    exp_st(SLPD_ON);
    @(posedge clk) rx_valid <= 3'h0;
    cyc(7400);
    #1 cmp_bit(1'h1, o_invalid_n);
    cyc(120);
    #1 cmp_bit(1'h0, o_invalid_n);
    exp_st(SLPD_AUTO_DOWN);
    @(posedge clk) rx_valid <= 3'(1 << ($urandom % 3));
    cyc(118);
    #1 cmp_bit(1'h0, o_invalid_n);
    cyc(10);
    #1 cmp_bit(1'h1, o_invalid_n);
    @(posedge clk) sel <= 2'h1;
    exp_st(SLPD_ON);
    @(posedge clk) rx_valid <= 3'h0;
    cyc(7530);
    exp_st(SLPD_FORCED_DOWN);
    @(posedge clk) rx_valid <= 3'h4;
    cyc(130);
    exp_st(SLPD_ON);
    @(posedge clk) {sel, rx_valid} <= {2'h2, 3'h0};
    cyc(7530);
    exp_st(SLPD_FORCED_DOWN);
    @(posedge clk) rx_valid <= 3'h2;
    cyc(130);
    exp_st(SLPD_AUTO_DOWN);
    @(posedge clk) tx <= tx ^ 5'(1 << ($urandom % 5));
    exp_st(SLPD_ON);
    summarize();
  end
endmodule : testbench
